// File: core/adcsq_pkg.sv
// constants, register layout and carrier types of the converter sequencer
// assumes a 20 MHz pclk; one state of the converter is one pclk cycle
package adcsq_pkg;
   // register byte addresses (word aligned)
   localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000;
   localparam logic [11:0] ADDR_TRIG_CTRL   = 12'h004;
   localparam logic [11:0] ADDR_DATA0       = 12'h010;
   localparam logic [11:0] ADDR_ANALOG      = 12'h020;
   // control/status field positions
   localparam int BIT_END_FLAG  = 7;
   localparam int BIT_IRQ_EN    = 6;
   localparam int BIT_START     = 5;
   localparam int BIT_SCAN      = 4;
   localparam int BIT_SPEED     = 3;
   localparam int BIT_TRIG_EN   = 7;
   localparam int BIT_TRIG_RSV0 = 0;
   localparam logic [7:0] TRIG_ONES_MASK = 8'h7e;
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   // timing in states; a state is one pclk
   localparam int CLK_MHZ        = 20;
   localparam int DELAY_SLOW_MIN = 6;
   localparam int DELAY_FAST_MIN = 4;
   localparam int PHASE_SLOW     = 4; // 6..9 spread
   localparam int PHASE_FAST     = 2; // 4..5 spread
   localparam int SAMPLE_SLOW    = 31;
   localparam int SAMPLE_FAST    = 15;
   localparam int TOTAL_SLOW     = 134;
   localparam int TOTAL_FAST     = 70;
   localparam int SCAN_SLOW      = 128;
   localparam int SCAN_FAST      = 66;
   localparam int RES_BITS       = 10;
   localparam int NUM_CHAN       = 4;
   // conversion time after sampling, first conversion at its longest delay
   localparam int CONV_SLOW = TOTAL_SLOW - SAMPLE_SLOW - (DELAY_SLOW_MIN + PHASE_SLOW - 1);
   localparam int CONV_FAST = TOTAL_FAST - SAMPLE_FAST - (DELAY_FAST_MIN + PHASE_FAST - 1);
   // per-bit step, rounded down; only the fast conversion time is a round multiple of it
   localparam int STEP_SLOW = CONV_SLOW / RES_BITS;
   localparam int STEP_FAST = CONV_FAST / RES_BITS;
   // the gap also absorbs the step rounding, so the scan period stays exact
   localparam logic [7:0] SCAN_GAP_SLOW = 8'(SCAN_SLOW - SAMPLE_SLOW - STEP_SLOW * RES_BITS);
   localparam logic [7:0] SCAN_GAP_FAST = 8'(SCAN_FAST - SAMPLE_FAST - STEP_FAST * RES_BITS);

   typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONV, ST_GAP} adcsq_phase_t;

   typedef struct packed {
      logic                end_flag;
      logic                end_flag_seen;
      logic                irq_en;
      logic                start;
      logic                scan;
      logic                speed;
      logic [2:0]          chan_sel;
      logic                trig_en;
      logic                trig_rsv0;
   } adcsq_ctrl_t;

   typedef struct packed {
      logic [3:0]          trig_sync;
      adcsq_phase_t        phase;
      logic [7:0]          count;
      logic [1:0]          prescale;
      logic [1:0]          chan;
      logic [RES_BITS-1:0] trial;
      logic [RES_BITS-1:0] sample;
      logic [3:0]          bitpos;
   } adcsq_seq_t;
endpackage

// File: core/adcsq_top.sv
// sequencer, successive approximation engine and apb register file
// assumes the analog front end delivers a digitised held level on analog_level;
// each trial is compared against the held sample internally; apb master keeps the bus stable
`timescale 1ns/100ps
module adcsq_top #(
   parameter int RES_BITS = 10,
   parameter int NUM_CHAN = 4
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                external_trigger_pin,
   input  wire logic [RES_BITS-1:0] analog_level,
   output logic      [1:0]          analog_mux_sel,
   output logic                     sample_hold,
   output logic                     conversion_end_irq
);
   // the sequencer state is laid out for the package widths only
   if (RES_BITS != adcsq_pkg::RES_BITS || NUM_CHAN != adcsq_pkg::NUM_CHAN) begin : g_param_check
      $error("adcsq_top: only ten bits and four inputs are supported");
   end

   typedef struct packed {
      adcsq_pkg::adcsq_ctrl_t  ctrl;
      adcsq_pkg::adcsq_seq_t   seq;
      logic [NUM_CHAN-1:0][RES_BITS-1:0] data;
      logic [31:0]             rdata;
   } adcsq_state_t;

   adcsq_state_t state;
   adcsq_state_t next_state;

   logic wr;
   logic rd;
   logic trig_fall;
   logic [1:0] last_chan;
   logic [1:0] pick;
   logic [7:0] delay_min;
   logic [7:0] sample_len;
   logic [7:0] conv_step;
   logic [RES_BITS-1:0] probe;
   logic cmp_high;

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign pready = 1'b1; // every register answers in the access cycle
   assign pslverr = 1'b0;
   assign prdata = state.rdata;
   assign analog_mux_sel = state.seq.chan;
   assign sample_hold = (state.seq.phase == adcsq_pkg::ST_SAMPLE);
   assign conversion_end_irq = state.ctrl.end_flag && state.ctrl.irq_en;

   // falling edge: stages two and three agree low while the agreed level is still high;
   // a one-cycle glitch never moves the agreed level, so it cannot start a conversion
   assign trig_fall = state.seq.trig_sync[3] && !state.seq.trig_sync[2] && !state.seq.trig_sync[1];

   // timing per speed setting
   always_comb begin
      if (state.ctrl.speed) begin
         delay_min  = 8'(adcsq_pkg::DELAY_FAST_MIN);
         sample_len = 8'(adcsq_pkg::SAMPLE_FAST);
         conv_step  = 8'(adcsq_pkg::STEP_FAST);
      end else begin
         delay_min  = 8'(adcsq_pkg::DELAY_SLOW_MIN);
         sample_len = 8'(adcsq_pkg::SAMPLE_SLOW);
         conv_step  = 8'(adcsq_pkg::STEP_SLOW);
      end
   end

   // channel picked in single mode, last channel of the scan group
   assign pick = state.ctrl.chan_sel[1:0];
   assign last_chan = state.ctrl.chan_sel[1:0];
   assign probe = state.seq.trial | (RES_BITS'(1) << state.seq.bitpos);
   assign cmp_high = (state.seq.sample >= probe);

   always_comb begin
      next_state = state;
      // three stages; bit 3 keeps the level that stages two and three last agreed on
      next_state.seq.trig_sync[2:0] = {state.seq.trig_sync[1:0], external_trigger_pin};
      if (state.seq.trig_sync[1] == state.seq.trig_sync[2])
         next_state.seq.trig_sync[3] = state.seq.trig_sync[2];
      next_state.seq.prescale = state.seq.prescale + 2'h1; // free internal phase

      unique case (state.seq.phase)
         adcsq_pkg::ST_IDLE: begin
            if (state.ctrl.start) begin
               next_state.seq.phase = adcsq_pkg::ST_DELAY;
               // extra wait follows the internal phase at the moment of the write;
               // this idle cycle is the first delay state, hence two off the minimum
               next_state.seq.count = delay_min - 8'h2 +
                  (state.ctrl.speed ? 8'(state.seq.prescale[0]) : 8'(state.seq.prescale));
               next_state.seq.chan = state.ctrl.scan ? 2'h0 : pick;
            end
         end
         adcsq_pkg::ST_DELAY, adcsq_pkg::ST_GAP: begin
            if (state.seq.count == 8'h0) begin
               next_state.seq.phase = adcsq_pkg::ST_SAMPLE;
               next_state.seq.count = sample_len - 8'h1;
            end else
               next_state.seq.count = state.seq.count - 8'h1;
         end
         adcsq_pkg::ST_SAMPLE: begin
            if (state.seq.count == 8'h0) begin
               next_state.seq.phase = adcsq_pkg::ST_CONV;
               next_state.seq.sample = analog_level; // held value
               next_state.seq.trial = '0;
               next_state.seq.bitpos = 4'(RES_BITS - 1);
               next_state.seq.count = conv_step - 8'h1;
            end else
               next_state.seq.count = state.seq.count - 8'h1;
         end
         adcsq_pkg::ST_CONV: begin
            if (state.seq.count != 8'h0)
               next_state.seq.count = state.seq.count - 8'h1;
            else begin
               if (cmp_high)
                  next_state.seq.trial = probe; // keep the trial bit
               next_state.seq.count = conv_step - 8'h1;
               if (state.seq.bitpos != 4'h0)
                  next_state.seq.bitpos = state.seq.bitpos - 4'h1;
               else begin
                  next_state.data[state.seq.chan] = cmp_high ? probe : state.seq.trial;
                  if (!state.ctrl.scan) begin
                     next_state.ctrl.end_flag = 1'b1;
                     next_state.ctrl.start = 1'b0;
                     next_state.seq.phase = adcsq_pkg::ST_IDLE;
                  end else begin
                     if (state.seq.chan == last_chan) begin
                        next_state.ctrl.end_flag = 1'b1;
                        next_state.seq.chan = 2'h0;
                     end else
                        next_state.seq.chan = state.seq.chan + 2'h1;
                     // fixed spacing for every later conversion
                     next_state.seq.phase = adcsq_pkg::ST_GAP;
                     next_state.seq.count = (state.ctrl.speed ? adcsq_pkg::SCAN_GAP_FAST
                                                             : adcsq_pkg::SCAN_GAP_SLOW) - 8'h1;
                  end
               end
            end
         end
         default: next_state.seq.phase = adcsq_pkg::ST_IDLE;
      endcase

      // pin trigger sets the same bit as software; placed after the case so it beats a single-mode clear
      if (state.ctrl.trig_en && trig_fall)
         next_state.ctrl.start = 1'b1;

      // apb write; selection and start in one write are taken together
      if (wr && paddr == adcsq_pkg::ADDR_CTRL_STATUS) begin
         next_state.ctrl.irq_en = pwdata[adcsq_pkg::BIT_IRQ_EN];
         next_state.ctrl.start = pwdata[adcsq_pkg::BIT_START];
         next_state.ctrl.scan = pwdata[adcsq_pkg::BIT_SCAN];
         next_state.ctrl.speed = pwdata[adcsq_pkg::BIT_SPEED];
         next_state.ctrl.chan_sel = pwdata[2:0];
         // zero write clears only after the flag was read as one; a fresh set wins
         if (!pwdata[adcsq_pkg::BIT_END_FLAG] && state.ctrl.end_flag_seen &&
             !(next_state.ctrl.end_flag && !state.ctrl.end_flag)) begin
            next_state.ctrl.end_flag = 1'b0;
            next_state.ctrl.end_flag_seen = 1'b0;
         end
         if (!pwdata[adcsq_pkg::BIT_START]) begin
            next_state.seq.phase = adcsq_pkg::ST_IDLE; // stop conversion
            if (state.ctrl.trig_en && trig_fall)
               next_state.ctrl.start = 1'b1; // pin edge beats the clear
         end
      end
      // seen only if the value handed to software showed the flag set
      if (rd && paddr == adcsq_pkg::ADDR_CTRL_STATUS && state.rdata[adcsq_pkg::BIT_END_FLAG])
         next_state.ctrl.end_flag_seen = 1'b1;
      if (wr && paddr == adcsq_pkg::ADDR_TRIG_CTRL) begin
         next_state.ctrl.trig_en = pwdata[adcsq_pkg::BIT_TRIG_EN];
         next_state.ctrl.trig_rsv0 = pwdata[adcsq_pkg::BIT_TRIG_RSV0]; // stored, unused
      end

      // read data registered at the setup edge, so it stands at the access edge
      if (psel && !penable && !pwrite) begin
         next_state.rdata = 32'h0;
         if (paddr == adcsq_pkg::ADDR_CTRL_STATUS)
            next_state.rdata = {24'h0, state.ctrl.end_flag, state.ctrl.irq_en, state.ctrl.start,
                                state.ctrl.scan, state.ctrl.speed, state.ctrl.chan_sel};
         else if (paddr == adcsq_pkg::ADDR_TRIG_CTRL)
            next_state.rdata = {24'h0, state.ctrl.trig_en, 6'h00, state.ctrl.trig_rsv0}
                               | {24'h0, adcsq_pkg::TRIG_ONES_MASK};
         else if (paddr >= adcsq_pkg::ADDR_DATA0 && paddr < adcsq_pkg::ADDR_ANALOG && paddr[1:0] == 2'h0)
            next_state.rdata = {22'h0, state.data[paddr[3:2]]};
      end
   end

   // single state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         state <= '0;
      else
         state <= next_state;
   end
endmodule

// File: tb/adcsq_analog_model.sv
// analog front end model: held, digitised level of the input on the mux
// assumes the level is settled whenever the mux select is stable
`timescale 1ns/100ps
module adcsq_analog_model (
   input  wire logic [1:0] mux_sel,
   input  wire logic [9:0] bias,
   output logic      [9:0] level
);
   // a distinct level per input, so a misrouted result shows
   assign level = (10'h0a5 + {mux_sel, 8'h11}) ^ bias;
endmodule

// File: tb/adcsq_monitor.sv
// port checker of the converter sequencer, bound to its top module
// assumes mode bits change only through apb writes to the control register
`timescale 1ns/100ps
module adcsq_monitor #(
   parameter int RES_BITS = 10,
   parameter int NUM_CHAN = 4
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [1:0]  analog_mux_sel,
   input wire logic        sample_hold,
   input wire logic        conversion_end_irq
);
   logic [7:0] gap, hi;
   logic       sh_q, gap_ok, scan, speed, irq_en, cut;
   logic [1:0] chan, last;
   wire        sh_rise = sample_hold & ~sh_q;
   wire        wr_ctrl = psel & penable & pwrite & pready & (paddr == adcsq_pkg::ADDR_CTRL_STATUS);
   // mirror of the mode bits; any control write voids the period check
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {sh_q, gap_ok, scan, speed, irq_en, cut, chan, last, gap, hi} <= '0;
      end else begin
         sh_q <= sample_hold;
         gap  <= sh_rise ? 8'h01 : gap + 8'h01;
         hi   <= sample_hold ? hi + 8'h01 : 8'h00;
         if (sh_rise) last <= analog_mux_sel;
         cut  <= wr_ctrl & ~pwdata[5]; // a stop write may cut a sampling window short
         if (wr_ctrl) begin
            {irq_en, scan, speed, chan} <= {pwdata[6], pwdata[4], pwdata[3], pwdata[1:0]};
            gap_ok <= 1'b0;
         end else if (sh_rise) begin
            gap_ok <= 1'b1;
         end
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_sample_end;
      sample_hold ##1 !sample_hold;
   endsequence
   AST_SINGLE_CHAN: assert property (sh_rise && !scan |-> analog_mux_sel == chan)
      else $error("single mode converted the wrong input");
   AST_SCAN_ORDER: assert property (sh_rise && scan |->
      analog_mux_sel == ((!gap_ok || last == chan) ? 2'h0 : last + 2'h1))
      else $error("scan visited inputs out of order");
   AST_SAMPLE_LEN: assert property ($fell(sample_hold) && !cut |-> hi == (speed ? 8'h0f : 8'h1f))
      else $error("sampling length wrong");
   AST_SCAN_PERIOD: assert property (sh_rise && scan && gap_ok |-> gap == (speed ? 8'h42 : 8'h80))
      else $error("scan conversion period wrong");
   AST_IRQ_EN: assert property (conversion_end_irq |-> irq_en || $past(irq_en))
      else $error("interrupt raised while disabled");
   AST_IRQ_QUIET: assert property ($rose(conversion_end_irq) |-> !sample_hold)
      else $error("interrupt raised during sampling");
   AST_CONV_AFTER: assert property (s_sample_end |=> !sample_hold [*8])
      else $error("no conversion after sampling");
   AST_MUX_HOLD: assert property (sample_hold && sh_q |-> $stable(analog_mux_sel))
      else $error("input changed while sampling");
endmodule
bind adcsq_top adcsq_monitor #(.RES_BITS(RES_BITS), .NUM_CHAN(NUM_CHAN)) mon_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .analog_mux_sel(analog_mux_sel),
   .sample_hold(sample_hold), .conversion_end_irq(conversion_end_irq));

// File: tb/adc_sequencer_control_tb_top.sv
// self-checking bench of the converter sequencer over apb
// assumes the analog model answers at once and read data stands at the access edge
`timescale 1ns/100ps
module adc_sequencer_control_tb_top;
   localparam logic [11:0] CS = adcsq_pkg::ADDR_CTRL_STATUS;
   localparam logic [11:0] DA = adcsq_pkg::ADDR_DATA0;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trig = 1, sh_d = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic        pready, pslverr, sample_hold, irq, err;
   logic [1:0]  mux;
   logic [9:0]  level, bias = '0;
   int          miscompares = 0, n_tests = 0, n_samp = 0, cyc = 0, t_samp = 0;
   adcsq_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_trigger_pin(trig), .analog_level(level), .analog_mux_sel(mux), .sample_hold(sample_hold),
      .conversion_end_irq(irq));
   adcsq_analog_model model_u (.mux_sel(mux), .bias(bias), .level(level));
   // 20 MHz clock
   initial forever #25 pclk = ~pclk;
   // count sampling windows to see whether conversions run, stamp the latest one
   always @(posedge pclk) begin
      sh_d <= sample_hold;
      cyc  <= cyc + 1;
      if (sample_hold && !sh_d) begin
         n_samp++;
         t_samp <= cyc;
      end
   end
   function automatic logic [31:0] lvl(input logic [1:0] ch, input logic [9:0] b);
      return {22'h0, (10'h0a5 + {ch, 8'h11}) ^ b};
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // one read; its data is taken at the access edge
   task automatic rd2(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic s_regs();
      rd2(CS);
      chk("ctrl reset", 32'h0, rd);
      apb(1'b1, adcsq_pkg::ADDR_TRIG_CTRL, 32'h80);
      rd2(adcsq_pkg::ADDR_TRIG_CTRL);
      chk("trig ctrl", 32'hfe, rd);
      apb(1'b1, adcsq_pkg::ADDR_TRIG_CTRL, 32'h0);
      rd2(adcsq_pkg::ADDR_TRIG_CTRL);
      chk("trig ctrl", 32'h7e, rd);
      apb(1'b1, 12'h0fc, 32'hffff_ffff);
      chk("pslverr", 32'h0, {31'h0, err});
      rd2(12'h0fc);
      chk("unmapped", 32'h0, rd);
   endtask
   // every input once, top select bit set on odd inputs, both speeds
   task automatic s_single();
      for (int ch = 0; ch < 4; ch++) begin
         logic [7:0] v;
         int         t_w;
         int         lo;
         int         hi_d;
         int         d;
         v = {1'b0, ch[0], 2'b10, ch[1], ch[0], ch[1:0]};
         apb(1'b1, CS, {24'h0, v});
         t_w = cyc;
         lo = ch[1] ? adcsq_pkg::DELAY_FAST_MIN : adcsq_pkg::DELAY_SLOW_MIN;
         hi_d = lo + (ch[1] ? adcsq_pkg::PHASE_FAST : adcsq_pkg::PHASE_SLOW);
         idle(150);
         // the first sampling cycle is seen one edge after it begins
         d = t_samp - t_w;
         chk("start delay", 32'h1, {31'h0, d > lo && d <= hi_d});
         chk("irq", {31'h0, ch[0]}, {31'h0, irq});
         rd2(CS);
         chk("ctrl done", {24'h0, v ^ 8'ha0}, rd);
         rd2(DA + 12'(4 * ch));
         chk("data", lvl(ch[1:0], 10'h0), rd);
         apb(1'b1, CS, {24'h0, v & 8'h5f});
         rd2(CS);
         chk("flag cleared", {24'h0, v & 8'h5f}, rd);
      end
   endtask
   task automatic s_scan(input logic sp);
      logic [7:0] v;
      int         k;
      v = 8'h32 | (sp ? 8'h48 : 8'h00);
      bias <= {sp, 9'h1ff};
      apb(1'b1, CS, {24'h0, v});
      idle(600);
      chk("scan irq", {31'h0, sp}, {31'h0, irq});
      rd2(CS);
      chk("scan ctrl", {24'h0, v | 8'h80}, rd);
      for (int ch = 0; ch < 3; ch++) begin
         rd2(DA + 12'(4 * ch));
         chk("scan data", lvl(ch[1:0], {sp, 9'h1ff}), rd);
      end
      rd2(DA + 12'h00c);
      chk("outside group", lvl(2'h3, 10'h0), rd);
      apb(1'b1, CS, {24'h0, v & 8'h5f});
      idle(2);
      k = n_samp;
      idle(300);
      chk("scan stopped", k, n_samp);
   endtask
   task automatic s_trig();
      int k;
      bias <= 10'h0;
      apb(1'b1, CS, 32'h01);
      k = n_samp;
      trig <= 1'b0;
      idle(4);
      trig <= 1'b1;
      idle(200);
      chk("trigger ignored", k, n_samp);
      apb(1'b1, adcsq_pkg::ADDR_TRIG_CTRL, 32'h80);
      trig <= 1'b0;
      idle(4);
      trig <= 1'b1;
      idle(200);
      chk("trigger start", k + 1, n_samp);
      apb(1'b1, CS, 32'h0);
      rd2(CS);
      chk("flag kept", 32'h80, rd);
      rd2(DA + 12'h004);
      chk("trig data", lvl(2'h1, 10'h0), rd);
   endtask
   task automatic results();
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // watchdog well beyond the few thousand cycles the run needs
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      results();
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      s_regs();
      s_single();
      s_scan(1'b0);
      s_scan(1'b1);
      s_trig();
      results();
   end
endmodule
